// ==== verilog/mms_pkg.sv ====
// package of register indices, field positions, codes and carriers for the memory interface
package mms_pkg;

	// register indices; the byte address on the bus is four times the index
	localparam logic [7:0]  IDX_WAITCFG  = 8'h63;
	localparam logic [7:0]  IDX_VERSION  = 8'h64;
	localparam logic [7:0]  IDX_MEMCFG   = 8'h66;
	localparam logic [7:0]  IDX_MISC     = 8'h70;
	localparam logic [7:0]  IDX_BANKCFG  = 8'hB1;
	localparam logic [7:0]  IDX_ASYMCFG  = 8'hB4;
	localparam logic [7:0]  IDX_STATUS   = 8'hC0;

	localparam int          PADDR_W      = 12;
	localparam logic [1:0]  IDX_PAD      = 2'h0;

	// reset value of every configuration register
	localparam logic [7:0]  REG_RESET    = 8'h00;

	// field positions
	localparam int          BIT_PAGE     = 0;
	localparam int          BIT_DRAM     = 1;
	localparam int          WS_LSB       = 0;
	localparam int          MS_LSB       = 2;
	localparam int          BIT_VER_EP   = 4;
	localparam int          BIT_SRAM_SEL = 0;
	localparam int          BIT_WAIT_HI  = 4;
	localparam int          BANK_LSB     = 6;
	localparam int          BIT_ASYM     = 7;

	// memory size codes and bank field codes
	localparam logic [2:0]  MS_1M_ONE    = 3'h1;
	localparam logic [2:0]  MS_2X1M      = 3'h2;
	localparam logic [2:0]  MS_2M_ONE    = 3'h3;
	localparam logic [2:0]  MS_2X2M      = 3'h4;
	localparam logic [2:0]  MS_8M_ONE    = 3'h5;
	localparam logic [2:0]  MS_2X8M      = 3'h6;
	localparam logic [1:0]  BF_2X512K    = 2'h1;
	localparam logic [1:0]  BF_2X2M      = 2'h3;

	// sram wait field codes
	localparam logic [1:0]  WS_FAST      = 2'h0;
	localparam logic [1:0]  WS_SLOW      = 2'h1;
	localparam logic [1:0]  WAIT_0       = 2'h0;
	localparam logic [1:0]  WAIT_1       = 2'h1;
	localparam logic [1:0]  WAIT_2       = 2'h2;

	// configuration seen by the address and select logic
	typedef struct packed {
		logic       sram_sel;
		logic       enh_page;
		logic       dram_bit;
		logic [1:0] ws_field;
		logic [2:0] ms;
		logic       asym;
		logic [1:0] bank_field;
		logic       wait_hi;
	} mms_cfg_s;

	// translated dram address
	typedef struct packed {
		logic [11:0] row;
		logic [11:0] col;
		logic        bank;
	} mms_xlat_s;

	// sequencer states, gray coded along idle-row-col and idle-sram-done; col to done and done to idle change two bits
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ROW  = 3'b001,
		ST_COL  = 3'b011,
		ST_SRAM = 3'b010,
		ST_DONE = 3'b110
	} mms_state_e;

endpackage : mms_pkg

// ==== verilog/mms_addr_xlat.sv ====
// cpu address to multiplexed dram row and column translation
`timescale 1ns/100ps
module mms_addr_xlat
	import mms_pkg::*;
(
	input  wire mms_pkg::mms_cfg_s  cfg,
	input  wire logic [23:1]        addr,
	output mms_pkg::mms_xlat_s      xlat
);
	// both page-control bits set arm the 16-Mbit asymmetric two-bank split
	localparam logic [1:0] WS_ASYM_BOTH = 2'h3;

	// the address bit that no strobe carries picks the bank; the enhanced splits interleave banks, the others use A20
	always_comb
	begin
		xlat.row  = {2'h0, addr[19:10]};
		xlat.col  = {3'h0, addr[9:1]};
		xlat.bank = addr[20];
		if (!cfg.enh_page)
		begin
			// normal page mode: plain symmetric split
			xlat.row  = {2'h0, addr[19:10]};
			xlat.col  = {3'h0, addr[9:1]};
			xlat.bank = addr[20];
		end
		else if (cfg.asym && cfg.bank_field == BF_2X2M && cfg.ws_field == WS_ASYM_BOTH)
		begin
			xlat.row  = {addr[20], addr[21], addr[19:10]};
			xlat.col  = {4'h0, addr[8:1]};
			xlat.bank = addr[9];
		end
		else if (cfg.asym && cfg.bank_field == BF_2X512K)
		begin
			xlat.row  = {3'h0, addr[18:11], addr[19]};
			xlat.col  = {3'h0, addr[9:1]};
			xlat.bank = addr[10];
		end
		else if (!cfg.asym && cfg.ms == MS_2X1M)
		begin
			xlat.row  = {2'h0, addr[19:11], addr[20]};
			xlat.col  = {3'h0, addr[9:1]};
			xlat.bank = addr[10];
		end
		else if (!cfg.asym && cfg.ms == MS_2X2M)
		begin
			xlat.row  = {2'h0, addr[19:12], addr[21], addr[20]};
			xlat.col  = {2'h0, addr[10:1]};
			xlat.bank = addr[11];
		end
		else if (!cfg.asym && cfg.ms == MS_2X8M)
		begin
			xlat.row  = {1'h0, addr[22], addr[19:13], addr[23], addr[21], addr[20]};
			xlat.col  = {1'h0, addr[11:1]};
			xlat.bank = addr[12];
		end
	end
endmodule : mms_addr_xlat

// ==== verilog/mms_sram_dec.sv ====
// sram byte select, bank split and wait state decode
`timescale 1ns/100ps
module mms_sram_dec
	import mms_pkg::*;
(
	input  wire mms_pkg::mms_cfg_s  cfg,
	input  wire logic [23:1]        addr,
	input  wire logic [1:0]         be,
	input  wire logic               write,
	output logic [3:0]              sel_n,
	output logic [1:0]              waits
);
	logic bank;

	// two-bank size codes split the space in half at the top of bank 0
	always_comb
	begin
		bank = 1'b0;
		if (cfg.ms == MS_2X1M)
			bank = addr[20];
		else if (cfg.ms == MS_2X2M)
			bank = addr[21];
		else if (cfg.ms == MS_2X8M)
			bank = addr[23];
	end

	// selects: 0 bank0 low, 1 bank0 high, 2 bank1 low, 3 bank1 high
	assign sel_n = ~(bank ? {be, 2'h0} : {2'h0, be});

	// wait field reused from the page controls while sram is selected
	always_comb
	begin
		if (cfg.ws_field == WS_FAST)
			waits = write ? WAIT_1 : WAIT_0;
		else if (cfg.ws_field == WS_SLOW && !cfg.wait_hi)
			waits = WAIT_1;
		else
			waits = WAIT_2;
	end
endmodule : mms_sram_dec

// ==== verilog/mms_top.sv ====
// main memory interface: apb configuration, dram address mux and sram cycles
// Contract
// - memcfg bit 0 chooses normal or enhanced page translation
// - enhanced, size code 010: row A19-A11,A20; column A9-A1
// - enhanced, size code 100: row A19-A12,A21,A20; column A10-A1
// - enhanced, size code 110: row A22,A19-A13,A23,A21,A20; column A11-A1
// - asymmetric, bank field 01: row A18-A11,A19; column A9-A1
// - asymmetric two 16-Mbit banks: row A20,A21,A19-A10; column A8-A1
// - memcfg bit 1 set for dram; under sram bits 1:0 are wait field
// - asymmetric addressing only for 512K x8 and 1M x16 parts
// - sram up to 16M, one or two 16-bit banks with byte selects
// - misc bit 0 selects sram; column strobes become byte chip selects
// - selects 0..3: bank0 low, bank0 high, bank1 low, bank1 high
// - sram drives full system address 23:1, write strobe as write enable
// - sram waits: 00 gives 0/1, 01 gives 1/1 or 2/2 by waitcfg bit 4
// - dram mux address shares the upper system address pins 23:12
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module mms_top
	import mms_pkg::*;
(
	input  wire logic                          CLK,
	input  wire logic                          RESETN,
	// apb slave
	input  wire logic                          PSEL,
	input  wire logic                          PENABLE,
	input  wire logic                          PWRITE,
	input  wire logic [mms_pkg::PADDR_W-1:0]   PADDR,
	input  wire logic [31:0]                   PWDATA,
	output logic [31:0]                        PRDATA,
	output logic                               PREADY,
	output logic                               PSLVERR,
	// cpu memory request
	input  wire logic                          REQ_VALID,
	input  wire logic                          REQ_WRITE,
	input  wire logic [23:1]                   REQ_ADDR,
	input  wire logic [1:0]                    REQ_BE,
	output logic                               REQ_DONE,
	output logic                               REQ_BUSY,
	// memory pins
	output logic [23:12]                       SYSTEM_ADDRESS_BUS_HI,
	output logic [11:1]                        SYSTEM_ADDRESS_BUS_LO,
	output logic [1:0]                         ROW_STROBE_N,
	output logic [3:0]                         COL_STROBE_N,
	output logic                               MEMORY_WRITE_STROBE_N
);
	import mms_pkg::*;

	localparam logic [PADDR_W-1:0] A_WAITCFG = {2'h0, IDX_WAITCFG, IDX_PAD};
	localparam logic [PADDR_W-1:0] A_VERSION = {2'h0, IDX_VERSION, IDX_PAD};
	localparam logic [PADDR_W-1:0] A_MEMCFG  = {2'h0, IDX_MEMCFG,  IDX_PAD};
	localparam logic [PADDR_W-1:0] A_MISC    = {2'h0, IDX_MISC,    IDX_PAD};
	localparam logic [PADDR_W-1:0] A_BANKCFG = {2'h0, IDX_BANKCFG, IDX_PAD};
	localparam logic [PADDR_W-1:0] A_ASYMCFG = {2'h0, IDX_ASYMCFG, IDX_PAD};
	localparam logic [PADDR_W-1:0] A_STATUS  = {2'h0, IDX_STATUS,  IDX_PAD};

	// idle levels of the active-low strobes
	localparam logic [1:0]         ROW_IDLE_N = 2'h3;
	localparam logic [3:0]         COL_IDLE_N = 4'hF;

	logic [7:0]   waitcfg_q;
	logic [7:0]   version_q;
	logic [7:0]   memcfg_q;
	logic [7:0]   misc_q;
	logic [7:0]   bankcfg_q;
	logic [7:0]   asymcfg_q;
	logic [31:0]  prdata_q;
	logic         pready_q;
	logic         pslverr_q;
	logic         setup;
	logic         wr_fire;
	logic         hit;
	logic [7:0]   rd_val;

	mms_cfg_s     cfg;
	mms_xlat_s    xlat;
	mms_xlat_s    xlat_q;
	logic [3:0]   sel_n;
	logic [1:0]   waits;

	mms_state_e   state_q;
	logic [1:0]   wait_q;
	logic [23:12] sa_hi_q;
	logic [11:1]  sa_lo_q;
	logic [1:0]   ras_n_q;
	logic [3:0]   cs_n_q;
	logic         we_n_q;
	logic         done_q;
	logic         write_q;
	logic [1:0]   be_q;
	logic         busy_q;

	// mux address lines onto the shared upper system address pins
	function automatic logic [23:12] ma_to_sa(input logic [11:0] ma);
		ma_to_sa = {ma[9:0], ma[10], ma[11]};
	endfunction : ma_to_sa

	// byte enables of the chosen dram bank placed on the four column strobes
	function automatic logic [3:0] bank_strobes_n(input logic bank, input logic [1:0] be);
		bank_strobes_n = ~(bank ? {be, 2'h0} : {2'h0, be});
	endfunction : bank_strobes_n

	assign setup   = PSEL && !PENABLE;
	assign wr_fire = PSEL && PENABLE && PWRITE && pready_q;

	// configuration image taken from the registers
	assign cfg.sram_sel   = misc_q[BIT_SRAM_SEL];
	assign cfg.enh_page   = memcfg_q[BIT_PAGE];
	assign cfg.dram_bit   = memcfg_q[BIT_DRAM];
	assign cfg.ws_field   = memcfg_q[WS_LSB +: 2];
	assign cfg.ms         = memcfg_q[MS_LSB +: 3];
	assign cfg.asym       = asymcfg_q[BIT_ASYM];
	assign cfg.bank_field = bankcfg_q[BANK_LSB +: 2];
	assign cfg.wait_hi    = waitcfg_q[BIT_WAIT_HI];

	mms_addr_xlat u_xlat
	(
		.cfg  (cfg),
		.addr (REQ_ADDR),
		.xlat (xlat)
	);

	mms_sram_dec u_sram
	(
		.cfg   (cfg),
		.addr  (REQ_ADDR),
		.be    (REQ_BE),
		.write (REQ_WRITE),
		.sel_n (sel_n),
		.waits (waits)
	);

	// read mux and address decode; unmapped offsets raise pslverr
	// status reads the busy flop, so software sees the same level as the pin
	always_comb
	begin
		hit    = 1'b1;
		rd_val = REG_RESET;
		if (PADDR == A_WAITCFG)
			rd_val = waitcfg_q;
		else if (PADDR == A_VERSION)
			rd_val = version_q;
		else if (PADDR == A_MEMCFG)
			rd_val = memcfg_q;
		else if (PADDR == A_MISC)
			rd_val = misc_q;
		else if (PADDR == A_BANKCFG)
			rd_val = bankcfg_q;
		else if (PADDR == A_ASYMCFG)
			rd_val = asymcfg_q;
		else if (PADDR == A_STATUS)
			rd_val = {4'h0, busy_q, state_q};
		else
			hit = 1'b0;
	end

	// apb answer: sampled in setup, presented through one access cycle
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q  <= setup;
			prdata_q  <= (setup && !PWRITE) ? {24'h00_0000, rd_val} : 32'h0000_0000;
			pslverr_q <= setup && !hit;
		end
	end

	// configuration writes; software owns the legality of combinations
	// a write lands only at the access edge, so a long setup never writes twice
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			waitcfg_q <= REG_RESET;
			version_q <= REG_RESET;
			memcfg_q  <= REG_RESET;
			misc_q    <= REG_RESET;
			bankcfg_q <= REG_RESET;
			asymcfg_q <= REG_RESET;
		end
		else if (wr_fire)
		begin
			if (PADDR == A_WAITCFG)
				waitcfg_q <= PWDATA[7:0];
			else if (PADDR == A_VERSION)
				version_q <= PWDATA[7:0];
			else if (PADDR == A_MEMCFG)
				memcfg_q <= PWDATA[7:0];
			else if (PADDR == A_MISC)
				misc_q <= PWDATA[7:0];
			else if (PADDR == A_BANKCFG)
				bankcfg_q <= PWDATA[7:0];
			else if (PADDR == A_ASYMCFG)
				asymcfg_q <= PWDATA[7:0];
		end
	end

	// access sequencer: dram row then column, or sram with wait states
	// requests seen while not idle are dropped; the caller waits for the done
	// pulse and one idle cycle, which keeps a single access outstanding
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			state_q <= ST_IDLE;
			wait_q  <= WAIT_0;
			xlat_q  <= '0;
			write_q <= 1'b0;
			be_q    <= 2'h0;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					if (REQ_VALID)
					begin
						xlat_q  <= xlat;
						write_q <= REQ_WRITE;
						be_q    <= REQ_BE;
						wait_q  <= waits;
						state_q <= cfg.sram_sel ? ST_SRAM : ST_ROW;
					end
				end
				ST_ROW:
					state_q <= ST_COL;
				ST_COL:
					state_q <= ST_DONE;
				ST_SRAM:
				begin
					if (wait_q == WAIT_0)
						state_q <= ST_DONE;
					else
						wait_q <= wait_q - 2'h1;
				end
				ST_DONE:
					state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// address pins: sram shows the system address, dram shows mux address on the upper pins
	// the pins hold their last value between accesses to save toggling
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			sa_hi_q <= 12'h000;
			sa_lo_q <= 11'h000;
		end
		else if (state_q == ST_IDLE && REQ_VALID)
		begin
			if (cfg.sram_sel)
			begin
				sa_hi_q <= REQ_ADDR[23:12];
				sa_lo_q <= REQ_ADDR[11:1];
			end
			else
			begin
				sa_hi_q <= ma_to_sa(xlat.row);
				sa_lo_q <= REQ_ADDR[11:1];
			end
		end
		else if (state_q == ST_ROW)
			sa_hi_q <= ma_to_sa(xlat_q.col);
	end

	// strobes: row strobe leads the column strobes by one cycle
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			ras_n_q <= ROW_IDLE_N;
			cs_n_q  <= COL_IDLE_N;
			we_n_q  <= 1'b1;
		end
		else if (state_q == ST_IDLE && REQ_VALID)
		begin
			if (cfg.sram_sel)
			begin
				cs_n_q <= sel_n;
				we_n_q <= !REQ_WRITE;
			end
			else
			begin
				ras_n_q <= xlat.bank ? 2'h1 : 2'h2;
				we_n_q  <= !REQ_WRITE;
			end
		end
		else if (state_q == ST_ROW)
			cs_n_q <= bank_strobes_n(xlat_q.bank, be_q);
		else if (state_q == ST_COL || (state_q == ST_SRAM && wait_q == WAIT_0))
		begin
			// every strobe drops together so no bank is left open after the access
			ras_n_q <= ROW_IDLE_N;
			cs_n_q  <= COL_IDLE_N;
			we_n_q  <= 1'b1;
		end
	end

	// busy flag: set at the take, cleared as the done pulse ends; a flop rather
	// than gates on the strobes, so the pin carries no combinational glitch
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			busy_q <= 1'b0;
		else if (state_q == ST_IDLE && REQ_VALID)
			busy_q <= 1'b1;
		else if (state_q == ST_DONE)
			busy_q <= 1'b0;
	end

	// completion pulse in the same cycle as the strobes release
	// it coincides with the done state, the one cycle before a new take is legal
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			done_q <= 1'b0;
		else
			done_q <= (state_q == ST_COL) || (state_q == ST_SRAM && wait_q == WAIT_0);
	end

	assign PRDATA                = prdata_q;
	assign PREADY                = pready_q;
	assign PSLVERR               = pslverr_q;
	assign REQ_DONE              = done_q;
	assign REQ_BUSY              = busy_q;
	assign SYSTEM_ADDRESS_BUS_HI = sa_hi_q;
	assign SYSTEM_ADDRESS_BUS_LO = sa_lo_q;
	assign ROW_STROBE_N          = ras_n_q;
	assign COL_STROBE_N          = cs_n_q;
	assign MEMORY_WRITE_STROBE_N = we_n_q;

endmodule : mms_top

// ==== tb/mms_chk_sva.sv ====
// port assertions for the main memory interface
`timescale 1ns/100ps
module mms_chk
(
	input wire logic        CLK,
	input wire logic        RESETN,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic [23:1] REQ_ADDR,
	input wire logic        REQ_DONE,
	input wire logic        REQ_BUSY,
	input wire logic [11:1] SYSTEM_ADDRESS_BUS_LO,
	input wire logic [1:0]  ROW_STROBE_N,
	input wire logic [3:0]  COL_STROBE_N,
	input wire logic        MEMORY_WRITE_STROBE_N
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	// apb answers one cycle after a setup cycle and at no other time
	a_ready_setup: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("pready missing after setup");
	a_ready_only: assert property (PREADY |-> $past(PSEL) && !$past(PENABLE))
		else $error("pready without setup");
	a_err_ready: assert property (PSLVERR |-> PREADY)
		else $error("pslverr outside access");
	// row strobe leads, column strobes follow one cycle later, then done
	a_row_then_col: assert property ($fell(&ROW_STROBE_N) |-> COL_STROBE_N == 4'hF ##1
		(COL_STROBE_N != 4'hF && !(&ROW_STROBE_N)) ##1 REQ_DONE)
		else $error("row and column order broken");
	// the longest sram cycle holds two waits
	a_done_bound: assert property ($rose(REQ_BUSY) |-> ##[1:3] REQ_DONE)
		else $error("access overran");
	a_done_idle: assert property (REQ_DONE |-> &ROW_STROBE_N && &COL_STROBE_N &&
		MEMORY_WRITE_STROBE_N && REQ_BUSY)
		else $error("strobes held at done");
	a_done_pulse: assert property (REQ_DONE |=> !REQ_DONE)
		else $error("done longer than a cycle");
	a_lo_addr: assert property ($fell(MEMORY_WRITE_STROBE_N) |->
		SYSTEM_ADDRESS_BUS_LO == $past(REQ_ADDR[11:1]))
		else $error("low address wrong at write");
endmodule : mms_chk

// ==== tb/mms_mem_model.sv ====
// memory chip model: latches what the pins present during each access
`timescale 1ns/100ps
module mms_mem_model
(
	input wire logic [0:0]   clk,
	input wire logic [23:12] sa_hi,
	input wire logic [11:1]  sa_lo,
	input wire logic [1:0]   row_n,
	input wire logic [3:0]   col_n,
	input wire logic         we_n
);
	logic [11:0] ma;
	logic [11:0] row_q;
	logic [11:0] col_q;
	logic [1:0]  bank_q;
	logic [3:0]  sel_q;
	logic [23:1] sa_q;
	logic        wr_q;

	// upper system address pins double as the dram mux lines
	assign ma = {sa_hi[12], sa_hi[13], sa_hi[23:14]};

	// a row opens with its strobe alone; column joins a cycle later
	always_ff @(posedge clk)
	begin
		if (row_n != 2'h3 && col_n == 4'hF) row_q <= ma;
		if (row_n != 2'h3 && col_n == 4'hF) bank_q <= row_n;
		if (row_n != 2'h3 && col_n != 4'hF) col_q <= ma;
		if (col_n != 4'hF) sel_q <= col_n;
		if (row_n == 2'h3 && col_n != 4'hF) sa_q <= {sa_hi, sa_lo};
		// write seen anywhere in the access; cleared once strobes idle
		wr_q <= (row_n != 2'h3 || col_n != 4'hF) ? (wr_q | ~we_n) : 1'b0;
	end
endmodule : mms_mem_model

// ==== tb/tb_main_memory_addr_map_and_sram_if.sv ====
// bench: register access, dram translation and sram cycles
`timescale 1ns/100ps
module tb_main_memory_addr_map_and_sram_if;
	import mms_pkg::*;
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0;
	logic REQ_VALID = 1'b0;
	logic REQ_WRITE = 1'b0;
	logic [23:1] REQ_ADDR = 23'h0;
	logic [1:0] REQ_BE = 2'h0;
	logic [31:0] PRDATA;
	logic PREADY, PSLVERR, REQ_DONE, REQ_BUSY, WE_N, b, err;
	logic [23:12] SA_HI;
	logic [11:1] SA_LO;
	logic [1:0] ROW_N;
	logic [3:0] COL_N, es;
	logic [23:1] a;
	logic [11:0] r, c, mr, mc;
	logic [31:0] rd;
	int error_cnt = 0;
	int samples_checked = 0;
	int lat, cyc = 0;
	// one bank code in normal mode: two 1M banks need enhanced mode
	logic [7:0] mcfg [6] = '{8'h06, 8'h0B, 8'h13, 8'h1B, 8'h03, 8'h03};
	logic [7:0] bcfg [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'hC0};
	// every configuration register reads back zero after reset
	logic [7:0] ridx [6] = '{IDX_WAITCFG, IDX_VERSION, IDX_MEMCFG, IDX_MISC,
		IDX_BANKCFG, IDX_ASYMCFG};

	mms_top dut(.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_BE(REQ_BE),
		.REQ_DONE(REQ_DONE), .REQ_BUSY(REQ_BUSY), .SYSTEM_ADDRESS_BUS_HI(SA_HI),
		.SYSTEM_ADDRESS_BUS_LO(SA_LO), .ROW_STROBE_N(ROW_N), .COL_STROBE_N(COL_N),
		.MEMORY_WRITE_STROBE_N(WE_N));
	mms_mem_model mma(.clk(CLK), .sa_hi(SA_HI), .sa_lo(SA_LO), .row_n(ROW_N), .col_n(COL_N),
		.we_n(WE_N));

	// free running clock and a hang guard
	always #5 CLK = ~CLK;
	always @(posedge CLK)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			error_cnt++;
			results();
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// one apb transfer; held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= {2'h0, idx, IDX_PAD};
		PWDATA <= wd;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do
			@(posedge CLK);
		while (PREADY !== 1'b1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb

	// one memory request; lat counts edges from take to done
	task automatic mem(input logic w, input logic [23:1] ad, input logic [1:0] be);
		@(posedge CLK);
		REQ_VALID <= 1'b1;
		REQ_WRITE <= w;
		REQ_ADDR <= ad;
		REQ_BE <= be;
		@(posedge CLK);
		REQ_VALID <= 1'b0;
		lat = 0;
		do
		begin
			@(posedge CLK);
			#1;
			lat++;
		end
		while (REQ_DONE !== 1'b1 && lat < 20);
	endtask : mem

	// expected row, column, valid line masks and bank bit per mode
	function automatic void xl(input int m);
		case (m)
			0: {r, c, mr, mc, b} = {2'h0, a[19:10], 3'h0, a[9:1], 12'h3FF, 12'h1FF, a[20]};
			1: {r, c, mr, mc, b} = {2'h0, a[19:11], a[20], 3'h0, a[9:1], 12'h3FF, 12'h1FF, a[10]};
			2: {r, c, mr, mc, b} = {2'h0, a[19:12], a[21], a[20], 2'h0, a[10:1], 12'h3FF, 12'h3FF,
				a[11]};
			3: {r, c, mr, mc, b} = {1'h0, a[22], a[19:13], a[23], a[21], a[20], 1'h0, a[11:1],
				12'h7FF, 12'h7FF, a[12]};
			4: {r, c, mr, mc, b} = {3'h0, a[18:11], a[19], 3'h0, a[9:1], 12'h1FF, 12'h1FF, a[10]};
			default: {r, c, mr, mc, b} = {a[20], a[21], a[19:10], 4'h0, a[8:1], 12'hFFF, 12'h0FF,
				a[9]};
		endcase
	endfunction : xl

	task automatic results;
		if (error_cnt == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	// reset, registers, dram modes, then sram wait settings
	initial
	begin
		repeat (5) @(posedge CLK);
		RESETN <= 1'b1;
		foreach (ridx[i])
		begin
			apb(1'b0, ridx[i], 32'h0);
			chk("register reset value", 32'h0, rd);
		end
		apb(1'b0, IDX_STATUS, 32'h0);
		chk("status idle", 32'h0, rd);
		apb(1'b1, 8'h00, 32'hFF);
		chk("unmapped error", 32'h1, err);
		apb(1'b1, IDX_VERSION, 32'h10);
		apb(1'b0, IDX_VERSION, 32'h0);
		chk("version readback", 32'h10, rd);
		for (int m = 0; m < 6; m++)
		begin
			apb(1'b1, IDX_BANKCFG, bcfg[m]);
			apb(1'b1, IDX_ASYMCFG, (m > 3) ? 32'h80 : 32'h0);
			apb(1'b1, IDX_MEMCFG, mcfg[m]);
			apb(1'b0, IDX_MEMCFG, 32'h0);
			chk("memcfg readback", mcfg[m], rd);
			for (int k = 0; k < 2; k++)
			begin
				a = k ? 23'h2AAAAA : 23'h555555;
				xl(m);
				mem(k[0], a, k ? 2'h2 : 2'h3);
				es = ~({2'h0, k ? 2'h2 : 2'h3} << (b ? 2 : 0));
				chk("dram latency", 32'd2, lat);
				chk("row address", r, mma.row_q & mr);
				chk("column address", c, mma.col_q & mc);
				chk("row strobe", b ? 2'h1 : 2'h2, mma.bank_q);
				chk("column strobes", es, mma.sel_q);
				chk("dram write strobe", k, mma.wr_q);
			end
		end
		apb(1'b1, IDX_ASYMCFG, 32'h0);
		apb(1'b1, IDX_MISC, 32'h1);
		for (int m = 0; m < 3; m++)
		begin
			apb(1'b1, IDX_WAITCFG, (m == 2) ? 32'h10 : 32'h0);
			apb(1'b1, IDX_MEMCFG, m ? 32'h09 : 32'h08);
			for (int k = 0; k < 2; k++)
			begin
				a = k ? 23'h2AAAAA : 23'h555555;
				mem(k[0], a, k ? 2'h2 : 2'h1);
				es = ~({2'h0, k ? 2'h2 : 2'h1} << (a[20] ? 2 : 0));
				chk("sram latency", m ? m + 1 : k + 1, lat);
				chk("sram address", a, mma.sa_q);
				chk("sram selects", es, mma.sel_q);
				chk("sram write enable", k, mma.wr_q);
			end
		end
		results();
	end
endmodule : tb_main_memory_addr_map_and_sram_if

bind mms_top mms_chk u_chk(.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .REQ_ADDR(REQ_ADDR), .REQ_DONE(REQ_DONE),
	.REQ_BUSY(REQ_BUSY), .SYSTEM_ADDRESS_BUS_LO(SYSTEM_ADDRESS_BUS_LO),
	.ROW_STROBE_N(ROW_STROBE_N), .COL_STROBE_N(COL_STROBE_N),
	.MEMORY_WRITE_STROBE_N(MEMORY_WRITE_STROBE_N));
